/* File: bench/krlt_bank_monitor.sv */
// concurrent checks on the bank's apb and limit ports
`timescale 1ns/1ps
module krlt_bank_monitor (
  input wire logic i_clk, // clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [krlt_pkg::ADDR_W-1:0] i_paddr, // byte address
  input wire logic [krlt_pkg::DATA_W-1:0] i_pwdata, // write data
  input wire logic [3:0] i_pstrb, // byte strobes
  input wire logic [krlt_pkg::DATA_W-1:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic [4:0] o_swing_ceiling, // max swing
  input wire logic [4:0] o_swing_floor, // min swing
  input wire logic [5:0] o_post_cursor_limit, // post limit
  input wire logic [4:0] o_pre_cursor_limit, // pre limit
  input wire logic [4:0] o_preset_main_tap // preset main
);
  import krlt_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // override word write in its access phase
  wire logic ovr_wr = i_psel && i_penable && i_pwrite
    && i_paddr == 14'h1358;
  AST_CEIL_SET: assert property (
    ovr_wr && $rose(i_penable) && i_pstrb[0] |-> ##2 o_swing_ceiling ==
    ($past(i_pwdata[5], 2) ? $past(i_pwdata[4:0], 2) :
    SWING_CEILING_DEFAULT)) else $error("ceiling");
  AST_FLOOR_SET: assert property (
    ovr_wr && $rose(i_penable) && i_pstrb[1] |-> ##2 o_swing_floor ==
    ($past(i_pwdata[13], 2) ? $past(i_pwdata[12:8], 2) :
    SWING_FLOOR_DEFAULT)) else $error("floor");
  AST_POST_SET: assert property (
    ovr_wr && $rose(i_penable) && i_pstrb[2] |-> ##2 o_post_cursor_limit ==
    ($past(i_pwdata[22], 2) ? $past(i_pwdata[21:16], 2) :
    POST_LIMIT_DEFAULT)) else $error("post");
  AST_PRE_SET: assert property (
    ovr_wr && $rose(i_penable) && i_pstrb[3] |-> ##2 o_pre_cursor_limit ==
    ($past(i_pwdata[29], 2) ? $past(i_pwdata[28:24], 2) :
    PRE_LIMIT_DEFAULT)) else $error("pre");
  AST_MAIN_TRACKS: assert property (
    o_preset_main_tap == o_swing_ceiling)
    else $error("preset main differs from ceiling");
  AST_LIMITS_HOLD: assert property (
    !$past(i_psel) && !$past(i_psel, 2) |-> $stable(o_swing_floor)
    && $stable(o_swing_ceiling) && $stable(o_post_cursor_limit)
    && $stable(o_pre_cursor_limit)) else $error("limit moved without a write");
  AST_RSVD_ZERO: assert property (
    i_psel && $rose(i_penable) && !i_pwrite && i_paddr >= 14'h135c
    && i_paddr <= 14'h13fc && i_paddr[1:0] == 2'b00
    |=> o_pready && !o_pslverr && o_prdata == ZERO_WORD) else $error("rsvd");
  AST_BAD_ALIGN: assert property (
    i_psel && $rose(i_penable) && i_paddr[1:0] != 2'b00
    |=> o_pready && o_pslverr) else $error("align");
  AST_ERR_READY: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
endmodule
bind krlt_bank krlt_bank_monitor i_mon (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_swing_ceiling(o_swing_ceiling), .o_swing_floor(o_swing_floor),
  .o_post_cursor_limit(o_post_cursor_limit),
  .o_pre_cursor_limit(o_pre_cursor_limit),
  .o_preset_main_tap(o_preset_main_tap));

/* File: bench/krlt_partner_model.sv */
// link partner side model: frame, tap and receive-equalisation strobes
`timescale 1ns/1ps
module krlt_partner_model (
  input wire logic i_clk, // clock
  output logic o_frame_valid, // frame strobe
  output logic [5:0] o_status, // coefficient status
  output logic o_rx_ready, // partner receiver trained level
  output logic [7:0] o_update, // update bits
  output logic o_tap_valid, // tap strobe
  output logic [4:0] o_swing, // trained swing
  output logic [5:0] o_post, // trained post cursor
  output logic [4:0] o_pre, // trained pre cursor
  output logic o_rxeq_valid, // rx eq strobe
  output logic [3:0] o_pkv, // peaking value
  output logic [1:0] o_pkk, // peaking kind
  output logic [1:0] o_fbk // feedback kind
);
  // quiet lines at time zero
  initial begin
    {o_frame_valid, o_status, o_rx_ready, o_update} = '0;
    {o_tap_valid, o_swing, o_post, o_pre} = '0;
    {o_rxeq_valid, o_pkv, o_pkk, o_fbk} = '0;
  end
  task automatic send_frame(input logic [5:0] st, input logic rdy,
                            input logic [7:0] up);
    o_frame_valid <= 1'b1;
    o_status <= st;
    o_rx_ready <= rdy;
    o_update <= up;
    @(posedge i_clk);
    o_frame_valid <= 1'b0;
    // released data shows the inverse, never the old value
    o_status <= ~st;
    o_update <= ~up;
  endtask
  // one-cycle strobe of new trained taps
  task automatic send_taps(input logic [4:0] s, input logic [5:0] po,
                           input logic [4:0] pr);
    o_tap_valid <= 1'b1;
    {o_swing, o_post, o_pre} <= {s, po, pr};
    @(posedge i_clk);
    o_tap_valid <= 1'b0;
    {o_swing, o_post, o_pre} <= ~{s, po, pr};
  endtask
  // one-cycle strobe of values sent to reconfiguration
  task automatic send_rxeq(input logic [3:0] v, input logic [1:0] k,
                           input logic [1:0] f);
    o_rxeq_valid <= 1'b1;
    {o_pkv, o_pkk, o_fbk} <= {v, k, f};
    @(posedge i_clk);
    o_rxeq_valid <= 1'b0;
    {o_pkv, o_pkk, o_fbk} <= ~{v, k, f};
  endtask
endmodule

/* File: bench/tb_krlt_bank.sv */
// self-checking bench for the link-training readback and override bank
`timescale 1ns/1ps
module tb_krlt_bank;
  import krlt_pkg::*;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, fv, rdy, tv, rv, ten;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, ovr, r;
  logic [3:0] pstrb, pkv, stb;
  logic [5:0] fst, post, postl, st;
  logic [32:0] m_now, e_now;
  logic [7:0] fup, pupd;
  logic [4:0] sw, pre, ceil, flr, prel, pmain;
  logic [1:0] pkk, fbk;
  logic [32:0] exp_q[$], msk_q[$];
  int failures, compares;
  krlt_partner_model i_lp (.i_clk(clk), .o_frame_valid(fv), .o_status(fst),
    .o_rx_ready(rdy), .o_update(fup), .o_tap_valid(tv), .o_swing(sw),
    .o_post(post), .o_pre(pre), .o_rxeq_valid(rv), .o_pkv(pkv),
    .o_pkk(pkk), .o_fbk(fbk));
  krlt_bank i_dut (.i_clk(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_frame_valid(fv), .i_frame_status(fst),
    .i_frame_rx_ready(rdy), .i_frame_update(fup), .i_tap_valid(tv),
    .i_tap_swing(sw), .i_tap_post(post), .i_tap_pre(pre),
    .i_rxeq_valid(rv), .i_peaking_filter_code(pkv), .i_peaking_mode(pkk),
    .i_feedback_mode(fbk), .o_swing_ceiling(ceil), .o_swing_floor(flr),
    .o_post_cursor_limit(postl), .o_pre_cursor_limit(prel),
    .o_preset_main_tap(pmain), .o_training_enable(ten),
    .o_partner_update(pupd));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; the expected answer is noted first
  task automatic apb(input logic w, input logic [13:0] a,
    input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so the next setup never reassigns psel in this step
    @(posedge clk);
  endtask
  // compare each answer with the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      m_now = msk_q.pop_front();
      e_now = exp_q.pop_front();
      check({pslverr, prdata} & m_now, e_now & m_now);
    end
  end
  task automatic lim_check;
    check(33'(ceil),
      33'(ovr[5] ? ovr[4:0] : SWING_CEILING_DEFAULT));
    check(33'(pmain),
      33'(ovr[5] ? ovr[4:0] : PRESET_MAIN_DEFAULT));
    check(33'(flr),
      33'(ovr[13] ? ovr[12:8] : SWING_FLOOR_DEFAULT));
    check(33'(postl),
      33'(ovr[22] ? ovr[21:16] : POST_LIMIT_DEFAULT));
    check(33'(prel),
      33'(ovr[29] ? ovr[28:24] : PRE_LIMIT_DEFAULT));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end
  initial begin
    {psel, pen, pwr, paddr, pwdata, ovr} = '0;
    pstrb = 4'hf;
    rstn = 1'b0;
    void'($urandom(32'h2931802e));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    lim_check;
    check(33'(ten), 33'h1);
    // every status code in every subfield, ready both ways
    for (int k = 0; k < 4; k++) begin
      st = 6'({2{k[1:0], ~k[1:0]}} >> 2);
      i_lp.send_frame(st, k[0], 8'(k * 37));
      repeat (5) @(posedge clk);
      apb(1'b0, 14'h1350, 0,
          {2'b0, k[0], st, 8'(k * 37), 16'h0}, 33'h17fff0000);
    end
    // trained taps and receive-equalisation capture, then a refused write
    repeat (4) begin
      r = $urandom;
      i_lp.send_taps(r[4:0], r[13:8], r[20:16]);
      i_lp.send_rxeq(r[27:24], r[29:28], r[31:30]);
      apb(1'b0, 14'h1354, 0, {1'b0, r}, 33'h1ff1f3f1f);
      apb(1'b1, 14'h1354, ~r, 33'h0, 33'h100000000);
      apb(1'b0, 14'h1354, 0, {1'b0, r}, 33'h1ff1f3f1f);
    end
    // override word with random enables and partial strobes
    repeat (8) begin
      r = $urandom & 32'h3f7f3f3f;
      r = (r | 32'h10200010) & 32'hffffefff;
      stb = 4'($urandom);
      pstrb <= stb;
      for (int b = 0; b < 4; b++) begin
        if (stb[b]) begin
          ovr[8*b+:8] = r[8*b+:8];
        end
      end
      apb(1'b1, 14'h1358, r, 33'h0, 33'h100000000);
      pstrb <= 4'hf;
      @(posedge clk);
      lim_check;
      apb(1'b0, 14'h1358, 0, {1'b0, ovr}, 33'h13f7f3f3f);
    end
    // reserved span, unmapped and misaligned addresses
    apb(1'b1, 14'h135c, r, 33'h0, 33'h100000000);
    apb(1'b0, 14'h135c, 0, 33'h0, 33'h1ffffffff);
    apb(1'b0, 14'h13fc, 0, 33'h0, 33'h1ffffffff);
    apb(1'b0, 14'h0000, 0, 33'h100000000, 33'h1ffffffff);
    apb(1'b0, 14'h1351, 0, 33'h100000000, 33'h1ffffffff);
    // update bits take a write only while training is off
    apb(1'b1, 14'h1340, 0, 33'h0, 33'h100000000);
    apb(1'b1, 14'h1350, 32'h00a50000, 33'h0, 33'h100000000);
    check(33'(ten), 33'h0);
    apb(1'b1, 14'h1340, 1, 33'h0, 33'h100000000);
    apb(1'b1, 14'h1350, 32'h005a0000, 33'h0, 33'h100000000);
    apb(1'b0, 14'h1350, 0, 33'h000a50000, 33'h100ff0000);
    check(33'(pupd), 33'h0a5);
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule

/* File: include/krlt_pkg.sv */
// shared constants for the link-training readback and override bank
package krlt_pkg;
  // word indices as printed (not multiples of four: byte address = 4*index)
  localparam logic [11:0] REG_PARTNER_REPORT_IDX = 12'h4d4;
  localparam logic [11:0] REG_READBACK_IDX = 12'h4d5;
  localparam logic [11:0] REG_OVERRIDE_IDX = 12'h4d6;
  localparam logic [11:0] REG_RESERVED_LAST_IDX = 12'h4ff;
  localparam logic [11:0] REG_TRAIN_CTRL_IDX = 12'h4d0;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  // partner report word fields
  localparam int PCR_LSB = 24;
  localparam int PCR_W = 6;
  localparam int PRT_BIT = 30;
  localparam int PCU_LSB = 16;
  localparam int PCU_W = 8;
  // coefficient status encodings
  localparam logic [1:0] COEF_MAXIMUM = 2'h3;
  localparam logic [1:0] COEF_MINIMUM = 2'h1;
  localparam logic [1:0] COEF_UPDATED = 2'h2;
  localparam logic [1:0] COEF_NOT_UPDATED = 2'h0;
  // readback word fields
  localparam int SWING_LSB = 0;
  localparam int SWING_W = 5;
  localparam int POST_LSB = 8;
  localparam int POST_W = 6;
  localparam int PRE_LSB = 16;
  localparam int PRE_W = 5;
  localparam int PKV_LSB = 24;
  localparam int PKV_W = 4;
  localparam int PKK_LSB = 28;
  localparam int FBK_LSB = 30;
  localparam int MODE_W = 2;
  // override word fields
  localparam int CEIL_LSB = 0;
  localparam int CEIL_EN_BIT = 5;
  localparam int FLOOR_LSB = 8;
  localparam int FLOOR_EN_BIT = 13;
  localparam int POSTL_LSB = 16;
  localparam int POSTL_W = 6;
  localparam int POSTL_EN_BIT = 22;
  localparam int PREL_LSB = 24;
  localparam int PREL_EN_BIT = 29;
  localparam int TAP5_W = 5;
  // own control word: bit 0 is local training enable
  localparam int TRAIN_EN_BIT = 0;
  localparam logic TRAIN_EN_RESET = 1'b1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  // default limit parameters (plain neutral values)
  localparam logic [4:0] SWING_CEILING_DEFAULT = 5'h1f;
  localparam logic [4:0] SWING_FLOOR_DEFAULT = 5'h09;
  localparam logic [5:0] POST_LIMIT_DEFAULT = 6'h19;
  localparam logic [4:0] PRE_LIMIT_DEFAULT = 5'h10;
  localparam logic [4:0] PRESET_MAIN_DEFAULT = 5'h1f;
endpackage

/* File: logic/krlt_apb_decode.sv */
`timescale 1ns/1ps
// apb address decoder for the bank's word slots
module krlt_apb_decode (
  input wire logic [krlt_pkg::ADDR_W-1:0] i_paddr, // byte address
  output logic o_sel_report, // partner report word
  output logic o_sel_readback, // trained readback word
  output logic o_sel_override, // override word
  output logic o_sel_ctrl, // training control word
  output logic o_sel_reserved, // reserved span, reads zero
  output logic o_misaligned // low address bits nonzero
);
  import krlt_pkg::*;
  logic [11:0] idx;
  // word index from byte address
  assign idx = i_paddr[ADDR_W-1:2];
  assign o_misaligned = |i_paddr[1:0];
  assign o_sel_report = (idx == REG_PARTNER_REPORT_IDX);
  assign o_sel_readback = (idx == REG_READBACK_IDX);
  assign o_sel_override = (idx == REG_OVERRIDE_IDX);
  assign o_sel_ctrl = (idx == REG_TRAIN_CTRL_IDX);
  assign o_sel_reserved = (idx > REG_OVERRIDE_IDX)
    && (idx <= REG_RESERVED_LAST_IDX);
endmodule

/* File: logic/krlt_bank.sv */
`timescale 1ns/1ps
// readback and override register bank for one lane's link training
// What this block does
// - partner coefficient report in bits 29:24
// - two-bit fields: max, min, updated, none
// - bit 30 shows partner receiver trained
// - readback 4:0 holds trained swing level
// - readback 13:8 holds trained post cursor
// - readback 20:16 holds trained pre cursor
// - capture peaking value, kind, feedback kind
// - bit 5 swaps swing ceiling limit
// - ceiling override also replaces preset main
// - bit 13 swaps swing floor limit
// - bit 22 swaps post cursor limit
// - bit 29 swaps pre cursor limit
// - words after override to 4ff reserved
// - update bits writable only training disabled
module krlt_bank (
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [krlt_pkg::ADDR_W-1:0] i_paddr, // apb byte address
  input wire logic [krlt_pkg::DATA_W-1:0] i_pwdata, // apb write data
  input wire logic [3:0] i_pstrb, // apb byte strobes
  output logic [krlt_pkg::DATA_W-1:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  // frame receiver strobes
  input wire logic i_frame_valid, // new frame received
  input wire logic [krlt_pkg::PCR_W-1:0] i_frame_status, // status word bits
  input wire logic i_frame_rx_ready, // partner receiver ready bit
  input wire logic [krlt_pkg::PCU_W-1:0] i_frame_update, // update word bits
  // coefficient update logic
  input wire logic i_tap_valid, // new trained taps
  input wire logic [krlt_pkg::SWING_W-1:0] i_tap_swing, // trained swing
  input wire logic [krlt_pkg::POST_W-1:0] i_tap_post, // trained post
  input wire logic [krlt_pkg::PRE_W-1:0] i_tap_pre, // trained pre
  // receive equalisation reconfiguration
  input wire logic i_rxeq_valid, // value sent to reconfig
  input wire logic [krlt_pkg::PKV_W-1:0] i_peaking_filter_code, // peaking
  input wire logic [krlt_pkg::MODE_W-1:0] i_peaking_mode, // peaking kind
  input wire logic [krlt_pkg::MODE_W-1:0] i_feedback_mode, // feedback kind
  // effective limits for the local transmitter
  output logic [4:0] o_swing_ceiling, // effective max swing
  output logic [4:0] o_swing_floor, // effective min swing
  output logic [5:0] o_post_cursor_limit, // effective post limit
  output logic [4:0] o_pre_cursor_limit, // effective pre limit
  output logic [4:0] o_preset_main_tap, // effective preset main
  output logic o_training_enable, // local training enable
  output logic [krlt_pkg::PCU_W-1:0] o_partner_update // update bits
);
  import krlt_pkg::*;

  // byte-lane merge used by the override and partner report words
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  typedef enum logic [1:0] {
    KRLT_IDLE = 2'h1,
    KRLT_DONE = 2'h2
  } krlt_apb_type;

  krlt_apb_type apb_q, apb_d;
  logic sel_report, sel_readback, sel_override, sel_ctrl, sel_reserved;
  logic misaligned;
  logic frame_rx_ready_s;
  logic [PCR_W-1:0] partner_coef_report_q;
  logic partner_rx_trained_flag_q;
  logic [PCU_W-1:0] partner_update_q;
  logic [SWING_W-1:0] trained_swing_level_q;
  logic [POST_W-1:0] trained_post_cursor_q;
  logic [PRE_W-1:0] trained_pre_cursor_q;
  logic [PKV_W-1:0] rx_peaking_value_q;
  logic [MODE_W-1:0] rx_peaking_kind_q;
  logic [MODE_W-1:0] rx_feedback_eq_kind_q;
  logic [DATA_W-1:0] override_q, override_d;
  logic train_en_q;
  logic [DATA_W-1:0] report_word, readback_word, ctrl_word, rdata_d;
  logic access, wr_acc, rd_acc, err_d, mapped;
  logic [DATA_W-1:0] report_wr;

  krlt_apb_decode u_decode (
    .i_paddr(i_paddr),
    .o_sel_report(sel_report),
    .o_sel_readback(sel_readback),
    .o_sel_override(sel_override),
    .o_sel_ctrl(sel_ctrl),
    .o_sel_reserved(sel_reserved),
    .o_misaligned(misaligned)
  );

  // receiver-ready bit arrives from the frame clock side as a level
  krlt_sync2 u_sync_ready (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(i_frame_rx_ready),
    .o_sync(frame_rx_ready_s)
  );

  // apb access phase qualification
  assign access = i_psel && i_penable && (apb_q == KRLT_IDLE);
  assign wr_acc = access && i_pwrite;
  assign rd_acc = access && !i_pwrite;
  assign mapped = !misaligned && (sel_report || sel_readback
    || sel_override || sel_ctrl || sel_reserved);
  assign err_d = access && !mapped;

  // one wait state: answer comes in the cycle after the access phase opens
  always_comb begin
    apb_d = apb_q;
    case (apb_q)
      KRLT_IDLE: begin
        if (access) begin
          apb_d = KRLT_DONE;
        end
      end
      KRLT_DONE: apb_d = KRLT_IDLE;
      default: apb_d = KRLT_IDLE;
    endcase
  end

  assign report_word = {1'b0, partner_rx_trained_flag_q,
    partner_coef_report_q, partner_update_q, 16'h0000};

  // swing, post and pre readback layout
  assign readback_word = {rx_feedback_eq_kind_q, rx_peaking_kind_q,
    rx_peaking_value_q, 3'h0, trained_pre_cursor_q, 2'h0,
    trained_post_cursor_q, 3'h0, trained_swing_level_q};

  assign ctrl_word = {31'h0, train_en_q};

  // reserved span and errors read as zero
  assign rdata_d = !rd_acc || !mapped ? ZERO_WORD :
    sel_report ? report_word :
    sel_readback ? readback_word :
    sel_override ? override_q :
    sel_ctrl ? ctrl_word : ZERO_WORD;

  assign override_d = merge_bytes(override_q, i_pwdata, i_pstrb);
  assign report_wr = merge_bytes(report_word, i_pwdata, i_pstrb);

  // apb state and answer registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      apb_q <= KRLT_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= ZERO_WORD;
    end else begin
      apb_q <= apb_d;
      o_pready <= access;
      o_pslverr <= err_d;
      o_prdata <= rdata_d;
    end
  end

  // software-written words
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      override_q <= ZERO_WORD;
      train_en_q <= TRAIN_EN_RESET;
    end else begin
      if (wr_acc && mapped && sel_override) begin
        override_q <= override_d;
      end
      if (wr_acc && mapped && sel_ctrl && i_pstrb[0]) begin
        train_en_q <= i_pwdata[TRAIN_EN_BIT];
      end
    end
  end

  // partner report capture: status from each received frame, update bits only while training, trained flag every cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      partner_coef_report_q <= 6'h00;
      partner_rx_trained_flag_q <= 1'b0;
      partner_update_q <= 8'h00;
    end else begin
      partner_rx_trained_flag_q <= frame_rx_ready_s;
      if (i_frame_valid) begin
        partner_coef_report_q <= i_frame_status;
      end
      // frame wins while training, software when disabled
      if (train_en_q && i_frame_valid) begin
        partner_update_q <= i_frame_update;
      end else if (!train_en_q && wr_acc && mapped && sel_report) begin
        partner_update_q <= report_wr[PCU_LSB +: PCU_W];
      end
    end
  end

  // readbacks change only on new values
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trained_swing_level_q <= 5'h00;
      trained_post_cursor_q <= 6'h00;
      trained_pre_cursor_q <= 5'h00;
      rx_peaking_value_q <= 4'h0;
      rx_peaking_kind_q <= 2'h0;
      rx_feedback_eq_kind_q <= 2'h0;
    end else begin
      if (i_tap_valid) begin
        trained_swing_level_q <= i_tap_swing;
        trained_post_cursor_q <= i_tap_post;
        trained_pre_cursor_q <= i_tap_pre;
      end
      if (i_rxeq_valid) begin
        rx_peaking_value_q <= i_peaking_filter_code;
        rx_peaking_kind_q <= i_peaking_mode;
        rx_feedback_eq_kind_q <= i_feedback_mode;
      end
    end
  end

  // effective limit selection, registered onto the outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_swing_ceiling <= SWING_CEILING_DEFAULT;
      o_swing_floor <= SWING_FLOOR_DEFAULT;
      o_post_cursor_limit <= POST_LIMIT_DEFAULT;
      o_pre_cursor_limit <= PRE_LIMIT_DEFAULT;
      o_preset_main_tap <= PRESET_MAIN_DEFAULT;
      o_training_enable <= TRAIN_EN_RESET;
      o_partner_update <= 8'h00;
    end else begin
      o_swing_ceiling <= override_q[CEIL_EN_BIT] ?
        override_q[CEIL_LSB +: TAP5_W] : SWING_CEILING_DEFAULT;
      o_preset_main_tap <= override_q[CEIL_EN_BIT] ?
        override_q[CEIL_LSB +: TAP5_W] : PRESET_MAIN_DEFAULT;
      o_swing_floor <= override_q[FLOOR_EN_BIT] ?
        override_q[FLOOR_LSB +: TAP5_W] : SWING_FLOOR_DEFAULT;
      o_post_cursor_limit <= override_q[POSTL_EN_BIT] ?
        override_q[POSTL_LSB +: POSTL_W] : POST_LIMIT_DEFAULT;
      o_pre_cursor_limit <= override_q[PREL_EN_BIT] ?
        override_q[PREL_LSB +: TAP5_W] : PRE_LIMIT_DEFAULT;
      o_training_enable <= train_en_q;
      o_partner_update <= partner_update_q;
    end
  end
endmodule

/* File: logic/krlt_sync2.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a level bit
module krlt_sync2 (
  input wire logic i_clk, // clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_async, // asynchronous level
  output logic o_sync // synchronised level
);
  logic meta_q;
  // first flop is read only by the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
